// ### rtl/usb_irq_defines.svh
`ifndef USB_IRQ_DEFINES_SVH
`define USB_IRQ_DEFINES_SVH

// register indices, byte address is four times the index
`define FRAME_NUM_IDX      10'h008
`define MFRAME_NUM_IDX     10'h009
`define LINK_IRQ_EN_IDX    10'h018
`define LINK_FLAGS_CLR_IDX 10'h01b
`define LINK_FLAGS_IDX     10'h01c
`define EP_IRQ_SUMMARY_IDX 10'h020
`define EP_STATUS_CLR_IDX  10'h104
`define EP_STATUS_SET_IDX  10'h105
`define EP_STATE_IDX       10'h106
`define EP_STRIDE_IDX      10'h020

// endpoint register slots within one stride
`define EP_SLOT_CLR        5'h00
`define EP_SLOT_SET        5'h01
`define EP_SLOT_STATE      5'h02

// link event flag positions
`define FLAG_WAKE_BIT      4
`define FLAG_RST_DONE_BIT  3
`define FLAG_SOF_BIT       2
`define FLAG_SUSPEND_BIT   0
`define LINK_FLAGS_MASK    16'h001d

// endpoint status bit 3 is unused
`define EP_STATE_MASK      8'hf7

// reset values
`define LINK_FLAGS_RESET   16'h0000
`define LINK_IRQ_EN_RESET  16'h0000
`define EP_SUMMARY_RESET   16'h0000
`define EP_STATE_RESET     8'h00

// timing
`define CLK_FREQ_KHZ       200000
`define SUSPEND_IDLE_MS    3
`define SUSPEND_IDLE_CYC   (`SUSPEND_IDLE_MS * `CLK_FREQ_KHZ)

// bus answers
`define RESP_OKAY          2'b00
`define RESP_SLVERR        2'b10

`endif

// ### rtl/usb_irq_epstat.sv
// Behaviour
// - wake activity sets flag bit 4, interrupts
// - bus reset end sets flag bit 3
// - start of frame sets bit 2, frame number
// - high speed start of frame clears microframe
// - idle J for 3 ms sets bit 0
// - writing one clears flag, zero keeps
// - read-only endpoint summary at index 0x20
// - summary bit clears when endpoint interrupt no longer pending
// - clear bits 7,6 drop bank ready
// - clear bits 5,4 drop stall requests
// - clear bit 2 drops current bank
// - clear bits 1,0 drop data toggles
// - set register at 0x105 plus n*0x20
`timescale 1ns/10ps
`include "usb_irq_defines.svh"

module usb_irq_epstat
  import usb_irq_pkg::*;
#(
  parameter int unsigned SUSPEND_IDLE_CYCLES = `SUSPEND_IDLE_CYC,
  parameter int unsigned NUM_EP              = 16
)(
  input  wire logic                        CLK,
  input  wire logic                        RST_N,
  input  wire logic [11:0]                 S_AXI_AWADDR,
  input  wire logic                        S_AXI_AWVALID,
  output logic                             S_AXI_AWREADY,
  input  wire logic [31:0]                 S_AXI_WDATA,
  input  wire logic [3:0]                  S_AXI_WSTRB,
  input  wire logic                        S_AXI_WVALID,
  output logic                             S_AXI_WREADY,
  output logic [1:0]                       S_AXI_BRESP,
  output logic                             S_AXI_BVALID,
  input  wire logic                        S_AXI_BREADY,
  input  wire logic [11:0]                 S_AXI_ARADDR,
  input  wire logic                        S_AXI_ARVALID,
  output logic                             S_AXI_ARREADY,
  output logic [31:0]                      S_AXI_RDATA,
  output logic [1:0]                       S_AXI_RRESP,
  output logic                             S_AXI_RVALID,
  input  wire logic                        S_AXI_RREADY,
  input  wire logic                        LINK_WAKE_EVT,
  input  wire logic                        BUS_RESET_END_EVT,
  input  wire logic                        SOF_EVT,
  input  wire logic [10:0]                 SOF_FRAME_NUM,
  input  wire logic                        MICROFRAME_EVT,
  input  wire logic                        HIGH_SPEED,
  input  wire logic                        LINE_J_IDLE,
  input  wire logic [NUM_EP-1:0]           EP_IRQ_PENDING,
  output endpoint_state_t [NUM_EP-1:0]     ENDPOINT_STATE,
  output logic                             IRQ
);

  localparam int unsigned IDLE_W = $clog2(SUSPEND_IDLE_CYCLES + 1);

  logic                  rst_meta_reg;
  logic                  rst_n_reg;
  logic                  idle_meta_reg;
  logic                  idle_sync_reg;
  logic [IDLE_W-1:0]     idle_cnt_reg;
  logic                  suspend_evt;
  link_event_flags_t     flags_reg;
  logic [15:0]           flag_set;
  logic [15:0]           flag_clr;
  logic [15:0]           irq_en_reg;
  logic [10:0]           frame_number_reg;
  logic [2:0]            microframe_number_reg;
  logic [NUM_EP-1:0]     summary_reg;
  logic [11:0]           aw_addr_reg;
  logic                  aw_full_reg;
  logic [31:0]           w_data_reg;
  logic [3:0]            w_strb_reg;
  logic                  w_full_reg;
  logic                  wr_fire;
  logic [9:0]            wr_idx;
  logic [9:0]            wr_ep_off;
  logic [3:0]            wr_ep;
  logic [4:0]            wr_slot;
  logic                  wr_ep_hit;
  logic                  wr_ok;
  logic [9:0]            rd_idx;
  logic [9:0]            rd_ep_off;
  logic [3:0]            rd_ep;
  logic [4:0]            rd_slot;
  logic                  rd_ep_hit;
  logic [31:0]           rd_data;
  logic                  rd_ok;

  // reset release through two flops
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // line idle level synchroniser
  always_ff @(posedge CLK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      idle_meta_reg <= 1'b0;
      idle_sync_reg <= 1'b0;
    end
    else
    begin
      idle_meta_reg <= LINE_J_IDLE;
      idle_sync_reg <= idle_meta_reg;
    end
  end

  // idle time counter, one suspend event per idle stretch
  always_ff @(posedge CLK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      idle_cnt_reg <= '0;
    else if (!idle_sync_reg)
      idle_cnt_reg <= '0;
    else if (idle_cnt_reg != IDLE_W'(SUSPEND_IDLE_CYCLES))
      idle_cnt_reg <= idle_cnt_reg + IDLE_W'(1);
  end

  assign suspend_evt = idle_sync_reg
                    && (idle_cnt_reg == IDLE_W'(SUSPEND_IDLE_CYCLES - 1));

  // write channel capture, address and data in either order
  assign S_AXI_AWREADY = !aw_full_reg && !S_AXI_BVALID;
  assign S_AXI_WREADY  = !w_full_reg && !S_AXI_BVALID;
  assign wr_fire       = aw_full_reg && w_full_reg && !S_AXI_BVALID;

  always_ff @(posedge CLK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= 12'h000;
    end
    else if (S_AXI_AWVALID && S_AXI_AWREADY)
    begin
      aw_full_reg <= 1'b1;
      aw_addr_reg <= S_AXI_AWADDR;
    end
    else if (wr_fire)
      aw_full_reg <= 1'b0;
  end

  always_ff @(posedge CLK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      w_full_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end
    else if (S_AXI_WVALID && S_AXI_WREADY)
    begin
      w_full_reg <= 1'b1;
      w_data_reg <= S_AXI_WDATA;
      w_strb_reg <= S_AXI_WSTRB;
    end
    else if (wr_fire)
      w_full_reg <= 1'b0;
  end

  // write address decode
  assign wr_idx    = aw_addr_reg[11:2];
  assign wr_ep_off = wr_idx - `EP_STATUS_CLR_IDX;
  assign wr_ep     = wr_ep_off[8:5];
  assign wr_slot   = wr_ep_off[4:0];
  assign wr_ep_hit = (wr_idx >= `EP_STATUS_CLR_IDX) && !wr_ep_off[9]
                  && (32'(wr_ep) < NUM_EP);

  always_comb
  begin
    wr_ok = 1'b0;
    if (wr_idx == `LINK_IRQ_EN_IDX || wr_idx == `LINK_FLAGS_IDX
        || wr_idx == `LINK_FLAGS_CLR_IDX)
      wr_ok = 1'b1;
    else if (wr_ep_hit && (wr_slot == `EP_SLOT_CLR || wr_slot == `EP_SLOT_SET))
      wr_ok = 1'b1;
  end

  // write response
  always_ff @(posedge CLK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= `RESP_OKAY;
    end
    else if (wr_fire)
    begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (S_AXI_BREADY)
      S_AXI_BVALID <= 1'b0;
  end

  // link event sources and software clears, set wins
  always_comb
  begin
    flag_set = 16'h0000;
    flag_clr = 16'h0000;
    flag_set[`FLAG_WAKE_BIT]     = LINK_WAKE_EVT;
    flag_set[`FLAG_RST_DONE_BIT] = BUS_RESET_END_EVT;
    flag_set[`FLAG_SOF_BIT]      = SOF_EVT;
    flag_set[`FLAG_SUSPEND_BIT]  = suspend_evt;
    if (wr_fire && (wr_idx == `LINK_FLAGS_IDX || wr_idx == `LINK_FLAGS_CLR_IDX))
    begin
      flag_clr[7:0]  = w_strb_reg[0] ? w_data_reg[7:0] : 8'h00;
      flag_clr[15:8] = w_strb_reg[1] ? w_data_reg[15:8] : 8'h00;
    end
  end

  always_ff @(posedge CLK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      flags_reg <= `LINK_FLAGS_RESET;
    else
      flags_reg <= ((flags_reg & ~flag_clr) | flag_set) & `LINK_FLAGS_MASK;
  end

  // interrupt enable register
  always_ff @(posedge CLK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      irq_en_reg <= `LINK_IRQ_EN_RESET;
    else if (wr_fire && wr_idx == `LINK_IRQ_EN_IDX)
    begin
      if (w_strb_reg[0])
        irq_en_reg[7:0] <= w_data_reg[7:0] & 8'(`LINK_FLAGS_MASK);
      if (w_strb_reg[1])
        irq_en_reg[15:8] <= w_data_reg[15:8];
    end
  end

  // level interrupt while any enabled flag is set
  assign IRQ = |(flags_reg & irq_en_reg & `LINK_FLAGS_MASK);

  // frame number capture on start of frame
  always_ff @(posedge CLK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      frame_number_reg <= 11'h000;
    else if (SOF_EVT)
      frame_number_reg <= SOF_FRAME_NUM;
  end

  // microframe count, cleared by high speed start of frame
  always_ff @(posedge CLK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      microframe_number_reg <= 3'h0;
    else if (SOF_EVT && HIGH_SPEED)
      microframe_number_reg <= 3'h0;
    else if (MICROFRAME_EVT && HIGH_SPEED)
      microframe_number_reg <= microframe_number_reg + 3'h1;
  end

  // endpoint summary follows pending interrupts
  always_ff @(posedge CLK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      summary_reg <= '0;
    else
      summary_reg <= EP_IRQ_PENDING;
  end

  // per endpoint status byte, set and clear strobes
  for (genvar e = 0; e < NUM_EP; e++)
  begin : g_ep
    logic hit;
    assign hit = wr_fire && wr_ep_hit && w_strb_reg[0] && (wr_ep == 4'(e));

    always_ff @(posedge CLK or negedge rst_n_reg)
    begin
      if (!rst_n_reg)
        ENDPOINT_STATE[e] <= `EP_STATE_RESET;
      else if (hit && wr_slot == `EP_SLOT_SET)
        ENDPOINT_STATE[e] <= (ENDPOINT_STATE[e] | w_data_reg[7:0])
                           & `EP_STATE_MASK;
      else if (hit && wr_slot == `EP_SLOT_CLR)
        ENDPOINT_STATE[e] <= ENDPOINT_STATE[e] & ~w_data_reg[7:0]
                           & `EP_STATE_MASK;
    end
  end

  // read address decode
  assign rd_idx    = S_AXI_ARADDR[11:2];
  assign rd_ep_off = rd_idx - `EP_STATUS_CLR_IDX;
  assign rd_ep     = rd_ep_off[8:5];
  assign rd_slot   = rd_ep_off[4:0];
  assign rd_ep_hit = (rd_idx >= `EP_STATUS_CLR_IDX) && !rd_ep_off[9]
                  && (32'(rd_ep) < NUM_EP);

  always_comb
  begin
    rd_data = 32'h0000_0000;
    rd_ok   = 1'b1;
    if (rd_idx == `LINK_FLAGS_IDX)
      rd_data = {16'h0000, flags_reg};
    else if (rd_idx == `LINK_IRQ_EN_IDX)
      rd_data = {16'h0000, irq_en_reg};
    else if (rd_idx == `FRAME_NUM_IDX)
      rd_data = {21'h000000, frame_number_reg};
    else if (rd_idx == `MFRAME_NUM_IDX)
      rd_data = {29'h00000000, microframe_number_reg};
    else if (rd_idx == `EP_IRQ_SUMMARY_IDX)
      rd_data = 32'(summary_reg);
    else if (rd_ep_hit && rd_slot == `EP_SLOT_STATE)
      rd_data = {24'h000000, ENDPOINT_STATE[rd_ep]};
    else if (rd_ep_hit && (rd_slot == `EP_SLOT_CLR || rd_slot == `EP_SLOT_SET))
      rd_data = 32'h0000_0000;
    else if (rd_idx == `LINK_FLAGS_CLR_IDX)
      rd_data = 32'h0000_0000;
    else
      rd_ok = 1'b0;
  end

  // read channel, one read in flight
  assign S_AXI_ARREADY = !S_AXI_RVALID;

  always_ff @(posedge CLK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0000_0000;
      S_AXI_RRESP  <= `RESP_OKAY;
    end
    else if (S_AXI_ARVALID && S_AXI_ARREADY)
    begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA  <= rd_data;
      S_AXI_RRESP  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (S_AXI_RREADY)
      S_AXI_RVALID <= 1'b0;
  end

endmodule : usb_irq_epstat

// ### rtl/usb_irq_pkg.sv
package usb_irq_pkg;

  // one endpoint's status byte
  typedef struct packed {
    logic bank1_ready;
    logic bank0_ready;
    logic bank1_stall_request;
    logic bank0_stall_request;
    logic unused;
    logic current_bank;
    logic in_data_toggle;
    logic out_data_toggle;
  } endpoint_state_t;

  // link event flags register layout
  typedef struct packed {
    logic [10:0] reserved_hi;
    logic        link_wake_flag;
    logic        bus_reset_done_flag;
    logic        sof_flag;
    logic        reserved_lo;
    logic        suspend_flag;
  } link_event_flags_t;

endpackage : usb_irq_pkg

// ### tb/testbench.sv
`timescale 1ns/10ps
`include "usb_irq_defines.svh"
module testbench;
  import usb_irq_pkg::*;
  localparam int unsigned SUSP = 20;
  logic                   CLK, RST_N, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY;
  logic                   S_AXI_ARVALID, S_AXI_RREADY, S_AXI_AWREADY, S_AXI_WREADY;
  logic                   S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, IRQ, HIGH_SPEED;
  logic                   LINK_WAKE_EVT, BUS_RESET_END_EVT, SOF_EVT, MICROFRAME_EVT, LINE_J_IDLE;
  logic [11:0]            S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0]            S_AXI_WDATA, S_AXI_RDATA, rd_q;
  logic [3:0]             S_AXI_WSTRB;
  logic [1:0]             S_AXI_BRESP, S_AXI_RRESP, resp;
  logic [10:0]            SOF_FRAME_NUM;
  logic [15:0]            EP_IRQ_PENDING;
  endpoint_state_t [15:0] ENDPOINT_STATE;
  int                     n_errors, check_count;
  usb_irq_epstat #(.SUSPEND_IDLE_CYCLES(SUSP)) DUT (.*);
  usb_host_model host (.*);
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic conclude;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude
  task automatic hang;
    n_errors++;
    conclude();
  endtask : hang
  // bus write: address and data offered together, each released when taken
  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    int t;
    @(posedge CLK);
    S_AXI_AWADDR <= {idx, 2'b00};
    S_AXI_WDATA  <= d;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'b111;
    for (t = 0; t < 40; t++)
    begin
      @(posedge CLK);
      if (S_AXI_AWREADY)
        S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY)
        S_AXI_WVALID <= 1'b0;
      if (S_AXI_BVALID)
        break;
    end
    resp = S_AXI_BRESP;
    S_AXI_BREADY <= 1'b0;
    if (t == 40)
      hang();
  endtask : wr
  // bus read into rd_q
  task automatic rd(input logic [9:0] idx);
    int t;
    @(posedge CLK);
    S_AXI_ARADDR <= {idx, 2'b00};
    {S_AXI_ARVALID, S_AXI_RREADY} <= 2'b11;
    for (t = 0; t < 40; t++)
    begin
      @(posedge CLK);
      if (S_AXI_ARREADY)
        S_AXI_ARVALID <= 1'b0;
      if (S_AXI_RVALID)
        break;
    end
    {rd_q, resp} = {S_AXI_RDATA, S_AXI_RRESP};
    S_AXI_RREADY <= 1'b0;
    if (t == 40)
      hang();
  endtask : rd
  task automatic s_reset;
    rd(`EP_IRQ_SUMMARY_IDX);
    check("summary", rd_q, 32'h0);
    rd(10'h3ff);
    check("unmapped data", rd_q, 32'h0);
    check("unmapped resp", resp, `RESP_SLVERR);
    check("irq after reset", IRQ, 1'b0);
    check("ep after reset", ENDPOINT_STATE[0], 8'h00);
  endtask : s_reset
  // wake, reset end and frame start alone, then masked, then alias clear
  task automatic s_link;
    logic [31:0] m;
    for (int k = 0; k < 3; k++)
    begin
      m = 32'h10 >> k;
      wr(`LINK_IRQ_EN_IDX, m);
      host.pulse(2'(k), 11'h0);
      repeat (2) @(posedge CLK);
      check("irq", IRQ, 1'b1);
      rd(`LINK_FLAGS_IDX);
      check("flag", rd_q, m);
      wr(`LINK_FLAGS_IDX, 32'h0);
      rd(`LINK_FLAGS_IDX);
      check("flag kept", rd_q, m);
      wr(`LINK_FLAGS_IDX, m);
      check("irq cleared", IRQ, 1'b0);
    end
    wr(`LINK_IRQ_EN_IDX, 32'h0);
    host.pulse(2'd0, 11'h0);
    repeat (2) @(posedge CLK);
    check("masked irq", IRQ, 1'b0);
    wr(`LINK_FLAGS_CLR_IDX, 32'h1d);
    rd(`LINK_FLAGS_IDX);
    check("alias clear", rd_q, 32'h0);
  endtask : s_link
  task automatic s_micro;
    host.line(1'b0, 1'b1);
    repeat (3) host.pulse(2'd3, 11'h0);
    rd(`MFRAME_NUM_IDX);
    check("microframe", rd_q, 32'h3);
    host.pulse(2'd2, 11'h7a5);
    rd(`MFRAME_NUM_IDX);
    check("microframe zero", rd_q, 32'h0);
    rd(`FRAME_NUM_IDX);
    check("frame", rd_q, 32'h7a5);
    host.line(1'b0, 1'b0);
  endtask : s_micro
  task automatic s_suspend;
    wr(`LINK_IRQ_EN_IDX, 32'h1);
    host.line(1'b1, 1'b0);
    repeat (SUSP + 1) @(posedge CLK);
    check("early suspend", IRQ, 1'b0);
    repeat (8) @(posedge CLK);
    check("suspend", IRQ, 1'b1);
    wr(`LINK_FLAGS_IDX, 32'h1);
    repeat (SUSP + 10) @(posedge CLK);
    check("once per idle", IRQ, 1'b0);
    host.line(1'b0, 1'b0);
  endtask : s_suspend
  // first and last endpoint, set then piecewise clear
  task automatic s_endpoints;
    logic [9:0] base;
    for (int i = 0; i < 16; i += 15)
    begin
      base = `EP_STATUS_CLR_IDX + 10'(i) * `EP_STRIDE_IDX;
      wr(base + 10'h1, 32'hff);
      check("ep set", ENDPOINT_STATE[i], 8'hf7);
      check("ep set resp", resp, `RESP_OKAY);
      wr(base, 32'h41);
      check("ep clr", ENDPOINT_STATE[i], 8'hb6);
      wr(base + 10'h1, 32'h0);
      wr(base, 32'h0);
      check("ep zero", ENDPOINT_STATE[i], 8'hb6);
      wr(base, 32'hb4);
      check("ep clr more", ENDPOINT_STATE[i], 8'h02);
      rd(base + 10'h2);
      check("ep read", rd_q, 32'h02);
      wr(base, 32'h02);
      check("ep toggle", ENDPOINT_STATE[i], 8'h00);
      S_AXI_WSTRB <= 4'he;
      wr(base + 10'h1, 32'hff);
      check("ep no strobe", ENDPOINT_STATE[i], 8'h00);
      S_AXI_WSTRB <= 4'hf;
    end
    check("ep other", ENDPOINT_STATE[7], 8'h00);
  endtask : s_endpoints
  task automatic s_summary;
    EP_IRQ_PENDING <= 16'h8001;
    repeat (2) @(posedge CLK);
    wr(`EP_IRQ_SUMMARY_IDX, 32'h0);
    check("summary ro resp", resp, `RESP_SLVERR);
    rd(`EP_IRQ_SUMMARY_IDX);
    check("summary set", rd_q, 32'h8001);
    EP_IRQ_PENDING <= 16'h0;
    repeat (2) @(posedge CLK);
    rd(`EP_IRQ_SUMMARY_IDX);
    check("summary gone", rd_q, 32'h0);
  endtask : s_summary
  // reset again in mid-run, state must be gone
  task automatic s_rerun;
    wr(`EP_STATUS_SET_IDX, 32'h81);
    check("ep before rerun", ENDPOINT_STATE[0], 8'h81);
    RST_N <= 1'b0;
    repeat (2) @(posedge CLK);
    check("ep in rerun", ENDPOINT_STATE[0], 8'h00);
    RST_N <= 1'b1;
    repeat (3) @(posedge CLK);
    check("irq after rerun", IRQ, 1'b0);
    rd(`EP_STATUS_CLR_IDX + 10'h2);
    check("ep read rerun", rd_q, 32'h0);
  endtask : s_rerun
  // 200 MHz clock
  initial
  begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end
  // reset, then the scenarios in turn
  initial
  begin
    {RST_N, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = '0;
    S_AXI_WSTRB    = 4'hf;
    EP_IRQ_PENDING = 16'h0;
    n_errors       = 0;
    check_count    = 0;
    repeat (5) @(posedge CLK);
    RST_N <= 1'b1;
    repeat (3) @(posedge CLK);
    s_reset();
    s_link();
    s_micro();
    s_suspend();
    s_endpoints();
    s_summary();
    s_rerun();
    conclude();
  end
endmodule : testbench

// ### tb/usb_host_model.sv
`timescale 1ns/10ps
module usb_host_model (
  input  wire logic   CLK,
  output logic        LINK_WAKE_EVT,
  output logic        BUS_RESET_END_EVT,
  output logic        SOF_EVT,
  output logic [10:0] SOF_FRAME_NUM,
  output logic        MICROFRAME_EVT,
  output logic        HIGH_SPEED,
  output logic        LINE_J_IDLE
);
  // quiet full speed link at time zero
  initial
  begin
    {LINK_WAKE_EVT, BUS_RESET_END_EVT, SOF_EVT, MICROFRAME_EVT} = 4'h0;
    SOF_FRAME_NUM = 11'h000;
    HIGH_SPEED    = 1'b0;
    LINE_J_IDLE   = 1'b0;
  end
  // one-cycle event: wake, reset end, frame start or microframe
  task automatic pulse(input logic [1:0] k, input logic [10:0] fn);
    @(posedge CLK);
    {LINK_WAKE_EVT, BUS_RESET_END_EVT, SOF_EVT, MICROFRAME_EVT} <= 4'h8 >> k;
    SOF_FRAME_NUM <= fn;
    @(posedge CLK);
    {LINK_WAKE_EVT, BUS_RESET_END_EVT, SOF_EVT, MICROFRAME_EVT} <= 4'h0;
    SOF_FRAME_NUM <= ~fn; // number only valid with the event
  endtask : pulse
  // line state and speed
  task automatic line(input logic idle, input logic hs);
    @(posedge CLK);
    LINE_J_IDLE <= idle;
    HIGH_SPEED  <= hs;
  endtask : line
endmodule : usb_host_model

// ### tb/usb_irq_epstat_properties.sv
`timescale 1ns/10ps
`include "usb_irq_defines.svh"
module usb_irq_epstat_checker
  import usb_irq_pkg::*;
#(
  parameter int unsigned SUSPEND_IDLE_CYCLES = 20
)(
  input wire logic                   CLK,
  input wire logic                   RST_N,
  input wire logic [11:0]            S_AXI_AWADDR,
  input wire logic                   S_AXI_AWVALID,
  input wire logic                   S_AXI_AWREADY,
  input wire logic [31:0]            S_AXI_WDATA,
  input wire logic [3:0]             S_AXI_WSTRB,
  input wire logic                   S_AXI_WVALID,
  input wire logic                   S_AXI_WREADY,
  input wire logic [1:0]             S_AXI_BRESP,
  input wire logic                   S_AXI_BVALID,
  input wire logic                   LINK_WAKE_EVT,
  input wire logic                   BUS_RESET_END_EVT,
  input wire logic                   SOF_EVT,
  input wire logic                   LINE_J_IDLE,
  input wire endpoint_state_t [15:0] ENDPOINT_STATE,
  input wire logic                   IRQ
);
  logic [9:0] aw_q;
  logic [9:0] rel;
  logic [7:0] w_q;
  logic [7:0] en_q;
  logic       ws_q;
  logic       bv_d;
  logic       done;
  logic       ep_wr;
  int         idle_cnt;
  // capture the write in flight, count idle cycles
  always_ff @(posedge CLK)
  begin
    if (S_AXI_AWVALID && S_AXI_AWREADY)
      aw_q <= S_AXI_AWADDR[11:2];
    if (S_AXI_WVALID && S_AXI_WREADY)
    begin
      w_q  <= S_AXI_WDATA[7:0];
      ws_q <= S_AXI_WSTRB[0];
    end
    idle_cnt <= LINE_J_IDLE ? idle_cnt + 1 : 0;
  end
  // first answer cycle of an accepted write
  assign done  = S_AXI_BVALID && !bv_d && S_AXI_BRESP == `RESP_OKAY && ws_q;
  assign rel   = aw_q - `EP_STATUS_CLR_IDX;
  assign ep_wr = done && aw_q >= `EP_STATUS_CLR_IDX && rel[4:0] <= `EP_SLOT_SET;
  // shadow of the interrupt enable
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      bv_d <= 1'b0;
      en_q <= 8'h00;
    end
    else
    begin
      bv_d <= S_AXI_BVALID;
      if (done && aw_q == `LINK_IRQ_EN_IDX)
        en_q <= w_q & 8'(`LINK_FLAGS_MASK);
    end
  end
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  property p_ep_set;
    ep_wr && rel[0] |-> (ENDPOINT_STATE[rel[8:5]] & w_q) == (w_q & `EP_STATE_MASK);
  endproperty
  a_ep_set: assert property (p_ep_set) else $error("set write missed a bit");
  property p_ep_clr;
    ep_wr && !rel[0] |-> (ENDPOINT_STATE[rel[8:5]] & w_q) == 8'h00;
  endproperty
  a_ep_clr: assert property (p_ep_clr) else $error("clear write missed a bit");
  property p_ep_keep;
    ep_wr |-> (ENDPOINT_STATE[rel[8:5]] & ~w_q) == ($past(ENDPOINT_STATE[rel[8:5]]) & ~w_q);
  endproperty
  a_ep_keep: assert property (p_ep_keep) else $error("unwritten bit moved");
  property p_wake;
    LINK_WAKE_EVT && en_q[4] && !S_AXI_BVALID |=> IRQ;
  endproperty
  a_wake: assert property (p_wake) else $error("no irq after wake");
  property p_rst_end;
    BUS_RESET_END_EVT && en_q[3] && !S_AXI_BVALID |=> IRQ;
  endproperty
  a_rst_end: assert property (p_rst_end) else $error("no irq after reset end");
  property p_sof;
    SOF_EVT && en_q[2] && !S_AXI_BVALID |=> IRQ;
  endproperty
  a_sof: assert property (p_sof) else $error("no irq after frame start");
  property p_suspend;
    idle_cnt == SUSPEND_IDLE_CYCLES + 5 && en_q[0] && !S_AXI_BVALID |-> IRQ;
  endproperty
  a_suspend: assert property (p_suspend) else $error("no irq after idle");
  property p_flag_clr;
    done && (aw_q == `LINK_FLAGS_IDX || aw_q == `LINK_FLAGS_CLR_IDX) && (w_q & en_q) == en_q
      && !$past(LINK_WAKE_EVT || BUS_RESET_END_EVT || SOF_EVT) && !LINE_J_IDLE |-> !IRQ;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("irq kept after clear");
endmodule : usb_irq_epstat_checker

bind usb_irq_epstat usb_irq_epstat_checker #(
  .SUSPEND_IDLE_CYCLES(SUSPEND_IDLE_CYCLES)
) u_checker (.*);
